// >>> core/igm_regs.svh
// register offsets, field positions, reset values and timing figures of the input gain and mute bank
`ifndef IGM_REGS_SVH
`define IGM_REGS_SVH

// register indices; the byte address on the bus is four times the index
`define IGM_IDX_RAMP        16'h0309
`define IGM_IDX_P1L         16'h0311
`define IGM_IDX_P1R         16'h0315
`define IGM_IDX_P2L         16'h0319
`define IGM_IDX_P2R         16'h031d
`define IGM_IDX_P3L         16'h0321
`define IGM_IDX_STATUS      16'h0330

// channel gain register fields
`define IGM_COMMIT_BIT      9
`define IGM_MUTE_BIT        8
`define IGM_CODE_MSB        7
`define IGM_CODE_RST        8'h80
`define IGM_MUTE_RST        1'b1
`define IGM_CODE_MAX        8'hbf

// ramp register fields
`define IGM_VD_MSB          6
`define IGM_VD_LSB          4
`define IGM_VI_MSB          2
`define IGM_VI_LSB          0
`define IGM_RAMP_RST        3'h2

// gain arithmetic: 0.125 dB per level step, four level steps per code step
`define IGM_LVL_PER_CODE    4
`define IGM_LVL_PER_OCT     48
`define IGM_LVL_UNITY_OFS   16

// ramp timing: the fastest rate is 0.5 ms per 6 dB, i.e. per 48 fine steps
`define IGM_CLK_PERIOD_NS   10
`define IGM_RAMP_UNIT_NS    500000

`endif

// >>> core/igm_pkg.sv
// types shared by the input gain and mute bank
package igm_pkg;

    localparam int NUM_CH = 5;

    typedef logic [9:0] igm_level_t;   // applied gain in 0.125 dB steps, 0 = -64 dB

    // whole state of the bank top
    typedef struct packed {
        logic [NUM_CH-1:0][7:0] code;       // stored gain codes
        logic [NUM_CH-1:0]      mute;       // stored mute bits
        logic [NUM_CH-1:0][9:0] target;     // committed target levels
        logic [NUM_CH-1:0]      app_mute;   // committed mute
        logic [NUM_CH-1:0][9:0] level;      // level now applied
        logic [NUM_CH-1:0][5:0] tick_cnt;   // ramp ticks since last step
        logic [11:0]            div_cnt;    // ramp unit divider
        logic                   tick;       // one-cycle ramp unit enable
        logic [2:0]             vd_rate;
        logic [2:0]             vi_rate;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
    } igm_state_t;

endpackage

// >>> core/igm_scaler.sv
// scales one sample by the linear factor of a gain level given in 0.125 dB steps
`timescale 1ns/100ps
`include "igm_regs.svh"

module igm_scaler
    import igm_pkg::*;
#(
    parameter int SAMPLE_W = 24
) (
    input  wire logic                clock_i,
    input  wire logic                rst_b_i,
    input  wire logic                in_valid_i,
    input  wire logic [2:0]          in_chan_i,
    input  wire logic [SAMPLE_W-1:0] in_data_i,
    input  wire logic [9:0]          level_i,
    input  wire logic                silent_i,
    output logic                     out_valid_o,
    output logic [2:0]               out_chan_o,
    output logic [SAMPLE_W-1:0]      out_data_o
);

    typedef struct packed {
        logic                valid;
        logic [2:0]          chan;
        logic [SAMPLE_W-1:0] data;
    } igm_scl_state_t;

    igm_scl_state_t st_ff;
    igm_scl_state_t nxt_st;

    //------------------------------------------------------------
    // gain arithmetic
    //------------------------------------------------------------
    // 2^(r/48) in q1.15; quadratic fit stays within about 0.03 dB of exact
    function automatic logic [16:0] igm_mantissa(input logic [5:0] r);
        logic [31:0] acc;
        acc = 32'(r) * (32'd21512 * 32'd48 + 32'd11256 * 32'(r));
        return 17'(32'd32768 + acc / 32'd2304);
    endfunction

    localparam logic signed [63:0] SAT_MAX = 64'sd1 <<< (SAMPLE_W - 1);

    //------------------------------------------------------------
    // scaling pipeline, one cycle
    //------------------------------------------------------------
    always_comb begin
        logic [10:0]        e;
        logic [4:0]         oct;
        logic [5:0]         rem;
        logic signed [63:0] prod;
        e    = 11'(level_i) + 11'(`IGM_LVL_UNITY_OFS);
        oct  = 5'(e / 11'(`IGM_LVL_PER_OCT));
        rem  = 6'(e % 11'(`IGM_LVL_PER_OCT));
        // octave 11 is unity; total shift is 15 fraction bits plus 11
        prod = (64'(signed'(in_data_i)) * signed'(64'(igm_mantissa(rem)))) <<< oct;
        prod = prod >>> 26;
        nxt_st.valid = in_valid_i;
        nxt_st.chan  = in_chan_i;
        if (silent_i) begin
            nxt_st.data = '0;
        end else if (prod >= SAT_MAX) begin
            nxt_st.data = SAMPLE_W'(SAT_MAX - 64'sd1);                   // clip rather than wrap on +31.5 dB
        end else if (prod < -SAT_MAX) begin
            nxt_st.data = SAMPLE_W'(-SAT_MAX);
        end else begin
            nxt_st.data = SAMPLE_W'(prod);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign out_valid_o = st_ff.valid;
    assign out_chan_o  = st_ff.chan;
    assign out_data_o  = st_ff.data;

endmodule

// >>> core/igm_bank.sv
// input path gain and mute bank: apb registers, commit, fine-step ramping and sample scaling
`timescale 1ns/100ps
`include "igm_regs.svh"

// Functional notes
// - writing 1 to bit 9 applies stored gain and mute of all channels together
// - commit bit sits at bit 9 of every channel register, same global effect
// - per-channel mute at bit 8, 1 silences, resets to 1
// - per-channel 8-bit gain code in bits 7:0, resets to 0x80 unity
// - code 0x00 is -64 dB, each code step adds 0.5 dB
// - highest valid code 0xbf gives +31.5 dB
// - gain registers for path 1 l/r, path 2 l/r, path 3 l
// - gain and mute changes ramp gradually at a programmable rate
// - values written without commit are stored but not applied
// - internal gain moves in 0.125 dB steps
module igm_bank
    import igm_pkg::*;
#(
    parameter int SAMPLE_W      = 24,
    parameter int RAMP_UNIT_CYC = `IGM_RAMP_UNIT_NS / `IGM_LVL_PER_OCT / `IGM_CLK_PERIOD_NS
) (
    input  wire logic                clock_i,
    input  wire logic                rst_b_i,
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [15:0]         paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    input  wire logic                sample_valid_i,
    input  wire logic [2:0]          sample_chan_i,
    input  wire logic [SAMPLE_W-1:0] sample_data_i,
    output logic                     out_valid_o,
    output logic [2:0]               out_chan_o,
    output logic [SAMPLE_W-1:0]      out_data_o
);

    igm_state_t st_ff;
    igm_state_t nxt_st;

    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    // channel register index to channel number, NUM_CH when not a channel
    function automatic logic [2:0] igm_chan_of(input logic [15:0] idx);
        case (idx)
            `IGM_IDX_P1L: return 3'h0;
            `IGM_IDX_P1R: return 3'h1;
            `IGM_IDX_P2L: return 3'h2;
            `IGM_IDX_P2R: return 3'h3;
            `IGM_IDX_P3L: return 3'h4;
            default:      return 3'(NUM_CH);
        endcase
    endfunction

    // target level: code steps are 0.5 dB, levels are 0.125 dB; mute aims at the floor
    function automatic logic [9:0] igm_target(input logic [7:0] code, input logic mute);
        return mute ? 10'h000 : 10'(code) * 10'(`IGM_LVL_PER_CODE);
    endfunction

    // ramp units per fine step: 0.5,1,2,4,8,15,30 ms per 6 dB
    function automatic logic [5:0] igm_rate_mult(input logic [2:0] rate);
        case (rate)
            3'h1:    return 6'h01;
            3'h2:    return 6'h02;
            3'h3:    return 6'h04;
            3'h4:    return 6'h08;
            3'h5:    return 6'h10;
            3'h6:    return 6'h1e;
            3'h7:    return 6'h3c;
            default: return 6'h00;
        endcase
    endfunction

    //------------------------------------------------------------
    // next state
    //------------------------------------------------------------
    always_comb begin
        logic [15:0] idx;
        logic [2:0]  wch;
        logic        wr;
        logic        commit;
        logic        up;
        logic [2:0]  rate;
        logic [5:0]  mult;
        nxt_st = st_ff;
        idx    = {2'h0, paddr_i[15:2]};
        wch    = igm_chan_of(idx);
        wr     = psel_i & penable_i & st_ff.pready & pwrite_i & ~st_ff.pslverr;
        commit = 1'b0;
        up     = 1'b0;
        rate   = 3'h0;
        mult   = 6'h00;

        // ramp unit divider
        nxt_st.tick = 1'b0;
        if (st_ff.div_cnt >= 12'(RAMP_UNIT_CYC - 1)) begin
            nxt_st.div_cnt = '0;
            nxt_st.tick    = 1'b1;
        end else begin
            nxt_st.div_cnt = st_ff.div_cnt + 12'h001;
        end

        // apb: setup cycle computes the answer, access phase completes in its first cycle with no wait state
        nxt_st.pready  = psel_i & ~penable_i;
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata  = '0;
        if (psel_i & ~penable_i) begin
            if (wch != 3'(NUM_CH)) begin
                nxt_st.prdata = {22'h0, 1'b0, st_ff.mute[wch], st_ff.code[wch]};
            end else if (idx == `IGM_IDX_RAMP) begin
                nxt_st.prdata = {25'h0, st_ff.vd_rate, 1'b0, st_ff.vi_rate};
            end else if (idx == `IGM_IDX_STATUS) begin
                // ramp in progress per channel, then applied mute per channel
                for (int c = 0; c < NUM_CH; c++) begin
                    nxt_st.prdata[c]     = (st_ff.level[c] != st_ff.target[c]);
                    nxt_st.prdata[8 + c] = st_ff.app_mute[c];
                end
            end else begin
                nxt_st.pslverr = 1'b1;                                   // unmapped address
            end
        end

        // register writes take effect at the access edge
        if (wr) begin
            if (wch != 3'(NUM_CH)) begin
                // codes 0xc0..0xff are reserved; stored as written, software keeps out of them
                nxt_st.code[wch] = pwdata_i[`IGM_CODE_MSB:0];
                nxt_st.mute[wch] = pwdata_i[`IGM_MUTE_BIT];
                commit           = pwdata_i[`IGM_COMMIT_BIT];
            end else if (idx == `IGM_IDX_RAMP) begin
                nxt_st.vd_rate = pwdata_i[`IGM_VD_MSB:`IGM_VD_LSB];
                nxt_st.vi_rate = pwdata_i[`IGM_VI_MSB:`IGM_VI_LSB];
            end
        end

        // commit loads every channel at once, including the value just written
        for (int c = 0; c < NUM_CH; c++) begin
            if (commit) begin
                nxt_st.target[c]   = igm_target(nxt_st.code[c], nxt_st.mute[c]);
                nxt_st.app_mute[c] = nxt_st.mute[c];
            end
        end

        // ramp each channel one 0.125 dB step per rate period toward its committed target
        for (int c = 0; c < NUM_CH; c++) begin
            up   = st_ff.target[c] > st_ff.level[c];
            rate = up ? st_ff.vi_rate : st_ff.vd_rate;
            mult = igm_rate_mult(rate);
            if (st_ff.level[c] == st_ff.target[c]) begin
                nxt_st.tick_cnt[c] = '0;
            end else if (mult == 6'h00) begin
                nxt_st.level[c]    = st_ff.target[c];
                nxt_st.tick_cnt[c] = '0;
            end else if (st_ff.tick) begin
                if (st_ff.tick_cnt[c] + 6'h01 >= mult) begin
                    nxt_st.tick_cnt[c] = '0;
                    nxt_st.level[c]    = up ? st_ff.level[c] + 10'h001
                                            : st_ff.level[c] - 10'h001;
                end else begin
                    nxt_st.tick_cnt[c] = st_ff.tick_cnt[c] + 6'h01;
                end
            end
        end
    end

    //------------------------------------------------------------
    // state register
    //------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            st_ff          <= '0;
            st_ff.vd_rate  <= `IGM_RAMP_RST;
            st_ff.vi_rate  <= `IGM_RAMP_RST;
            for (int c = 0; c < NUM_CH; c++) begin
                st_ff.code[c]     <= `IGM_CODE_RST;
                st_ff.mute[c]     <= `IGM_MUTE_RST;
                st_ff.app_mute[c] <= `IGM_MUTE_RST;
                st_ff.target[c]   <= 10'h000;
                st_ff.level[c]    <= 10'h000;
            end
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata_o  = st_ff.prdata;
    assign pready_o  = st_ff.pready;
    assign pslverr_o = st_ff.pslverr;

    //------------------------------------------------------------
    // sample path
    //------------------------------------------------------------
    // channel numbers beyond the bank are treated as muted so stray data never leaks out
    logic [9:0] sel_level;
    logic       sel_silent;
    always_comb begin
        sel_level  = 10'h000;
        sel_silent = 1'b1;
        if (sample_chan_i < 3'(NUM_CH)) begin
            sel_level  = st_ff.level[sample_chan_i];
            sel_silent = st_ff.app_mute[sample_chan_i] & (st_ff.level[sample_chan_i] == 10'h000);
        end
    end

    igm_scaler #(
        .SAMPLE_W (SAMPLE_W)
    ) u_scaler (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (sample_valid_i),
        .in_chan_i   (sample_chan_i),
        .in_data_i   (sample_data_i),
        .level_i     (sel_level),
        .silent_i    (sel_silent),
        .out_valid_o (out_valid_o),
        .out_chan_o  (out_chan_o),
        .out_data_o  (out_data_o)
    );

endmodule

// >>> sim/igm_bank_assertions.sv
// concurrent checks on the ports of the input gain and mute bank
`timescale 1ns/100ps
`include "igm_regs.svh"

module igm_bank_assertions
    import igm_pkg::*;
#(
    parameter int SAMPLE_W = 24
) (
    input wire logic                clock_i,
    input wire logic                rst_b_i,
    input wire logic                psel_i,
    input wire logic                penable_i,
    input wire logic                pwrite_i,
    input wire logic [15:0]         paddr_i,
    input wire logic [31:0]         pwdata_i,
    input wire logic [31:0]         prdata_o,
    input wire logic                pready_o,
    input wire logic                pslverr_o,
    input wire logic                sample_valid_i,
    input wire logic [2:0]          sample_chan_i,
    input wire logic [SAMPLE_W-1:0] sample_data_i,
    input wire logic                out_valid_o,
    input wire logic [2:0]          out_chan_o,
    input wire logic [SAMPLE_W-1:0] out_data_o
);
    // ------------------------------------------------------------
    // address decode of the setup cycle
    // ------------------------------------------------------------
    // own decode, kept apart from the design so a wrong map shows up
    logic [13:0] idx;
    logic        chn;
    logic        hit;
    logic        setup;
    assign idx   = paddr_i[15:2];
    assign chn   = idx inside {`IGM_IDX_P1L, `IGM_IDX_P1R, `IGM_IDX_P2L, `IGM_IDX_P2R, `IGM_IDX_P3L};
    assign hit   = chn || idx == `IGM_IDX_RAMP || idx == `IGM_IDX_STATUS;
    assign setup = psel_i && !penable_i;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    ready_after_setup_a: assert property (setup |=> pready_o) else $error("no ready after setup");
    ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
    ready_cause_a: assert property (pready_o |-> $past(setup)) else $error("ready without setup");
    rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside access");
    err_unmapped_a: assert property (setup && !hit |=> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (setup && hit |=> !pslverr_o) else $error("mapped access refused");
    err_with_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
    commit_reads_zero_a: assert property (setup && chn && !pwrite_i |=> prdata_o[31:9] == 23'h0)
        else $error("commit or reserved bits read nonzero");
    out_follows_a: assert property (sample_valid_i |=> out_valid_o && out_chan_o == $past(sample_chan_i))
        else $error("scaled sample missing or wrong channel");
    out_quiet_a: assert property (!sample_valid_i |=> !out_valid_o) else $error("spurious scaled sample");
    chan_none_zero_a: assert property (sample_valid_i && sample_chan_i > 3'h4 |=> out_data_o == '0)
        else $error("unused channel not zero");

    // main scenarios
    cover property (setup && pwrite_i && pwdata_i[`IGM_COMMIT_BIT]);
    cover property (pready_o && pslverr_o);
    cover property (out_valid_o && out_data_o != '0);
endmodule

// >>> sim/tb.sv
// self-checking bench of the input gain and mute bank
`timescale 1ns/100ps
`include "igm_regs.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module tb;
    localparam logic [15:0] A_P1L  = `IGM_IDX_P1L << 2;
    localparam logic [15:0] A_P1R  = `IGM_IDX_P1R << 2;
    localparam logic [15:0] A_P2L  = `IGM_IDX_P2L << 2;
    localparam logic [15:0] A_P2R  = `IGM_IDX_P2R << 2;
    localparam logic [15:0] A_P3L  = `IGM_IDX_P3L << 2;
    localparam logic [15:0] A_RAMP = `IGM_IDX_RAMP << 2;
    localparam logic [15:0] A_STAT = `IGM_IDX_STATUS << 2;
    logic        clock_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata_o, rd;
    logic        pready_o, pslverr_o, er;
    logic        svalid = 1'b0, out_valid_o;
    logic [2:0]  schan = 3'h0, out_chan_o;
    logic [23:0] sdata = 24'h0, out_data_o, got;
    int          fails = 0, comparisons = 0;

    always #5 clock_i = ~clock_i;

    igm_bank #(.SAMPLE_W(24), .RAMP_UNIT_CYC(2)) u_igm_bank (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .sample_valid_i(svalid), .sample_chan_i(schan), .sample_data_i(sdata),
        .out_valid_o(out_valid_o), .out_chan_o(out_chan_o), .out_data_o(out_data_o));

    // ------------------------------------------------------------
    // bus and sample tasks
    // ------------------------------------------------------------
    // apb master: holds the request until ready is seen at an edge, no fixed latency assumed
    // a slave that never answers is caught by the watchdog, which counts it as a mismatch
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
        @(posedge clock_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge clock_i);
        penable <= 1'b1;
        do begin @(posedge clock_i); end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input logic eerr);
        apb(1'b0, a, 32'h0);
        `CHK(rd, exp)
        `CHK(er, eerr)
    endtask

    // one sample in, the scaled sample taken in the cycle after it is accepted
    task automatic smp(input logic [2:0] ch, input logic [23:0] d);
        @(posedge clock_i);
        svalid <= 1'b1; schan <= ch; sdata <= d;
        @(posedge clock_i);
        svalid <= 1'b0;
        @(posedge clock_i);
        `CHK(out_valid_o, 1'b1)
        got = out_data_o;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdc(A_P1L, 32'h180, 1'b0);
        rdc(A_P1R, 32'h180, 1'b0);
        rdc(A_P2L, 32'h180, 1'b0);
        rdc(A_P2R, 32'h180, 1'b0);
        rdc(A_P3L, 32'h180, 1'b0);
        rdc(A_RAMP, 32'h22, 1'b0);
        rdc(A_STAT, 32'h1f00, 1'b0);
        rdc(16'h0c48, 32'h0, 1'b1);
    endtask

    // stored without commit: channel stays silent
    task automatic t_store();
        apb(1'b1, A_P1L, 32'h080);
        smp(3'h0, 24'h123456);
        `CHK(got, 24'h0)
        rdc(A_P1L, 32'h080, 1'b0);
    endtask

    // commit through another channel loads every channel at once
    task automatic t_commit();
        apb(1'b1, A_RAMP, 32'h0);
        apb(1'b1, A_P1R, 32'h080);
        apb(1'b1, A_P3L, 32'h280);
        repeat (5) @(posedge clock_i);
        smp(3'h0, 24'h123456);
        `CHK(got, 24'h123456)
        smp(3'h1, 24'h654321);
        `CHK(got, 24'h654321)
        smp(3'h4, 24'h0abcde);
        `CHK(got, 24'h0abcde)
        smp(3'h2, 24'h123456);
        `CHK(got, 24'h0)
        smp(3'h6, 24'h123456);
        `CHK(got, 24'h0)
        rdc(A_STAT, 32'h0c00, 1'b0);
    endtask

    // code points: top code saturates, -6 dB halves within rounding
    task automatic t_codes();
        apb(1'b1, A_P2L, 32'h2bf);
        apb(1'b1, A_P1L, 32'h274);
        repeat (5) @(posedge clock_i);
        smp(3'h2, 24'h100000);
        `CHK(got, 24'h7fffff)
        smp(3'h0, 24'h200000);
        `CHK(got >= 24'h0ff000 && got <= 24'h101000, 1'b1)
    endtask

    // slow rising ramp: 512 fine steps of two cycles each
    task automatic t_ramp();
        apb(1'b1, A_RAMP, 32'h01);
        apb(1'b1, A_P2R, 32'h280);
        repeat (20) @(posedge clock_i);
        apb(1'b0, A_STAT, 32'h0);
        `CHK(rd[4:0], 5'h08)
        repeat (540) @(posedge clock_i);
        apb(1'b0, A_STAT, 32'h0);
        `CHK(rd[4:0], 5'h08)
        smp(3'h3, 24'h400000);
        `CHK(got < 24'h100000, 1'b1)
        repeat (600) @(posedge clock_i);
        apb(1'b0, A_STAT, 32'h0);
        `CHK(rd[4:0], 5'h00)
        smp(3'h3, 24'h400000);
        `CHK(got, 24'h400000)
    endtask

    task automatic give_verdict();
        if (fails == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_store();
        t_commit();
        t_codes();
        t_ramp();
        give_verdict();
    end

    // the ramp dominates the run; a hang anywhere ends well past it
    initial begin
        repeat (6000) @(posedge clock_i);
        fails++;
        give_verdict();
    end
endmodule

bind igm_bank igm_bank_assertions #(.SAMPLE_W(SAMPLE_W)) u_igm_bank_assertions (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sample_valid_i(sample_valid_i), .sample_chan_i(sample_chan_i), .sample_data_i(sample_data_i),
    .out_valid_o(out_valid_o), .out_chan_o(out_chan_o), .out_data_o(out_data_o));
